// ---- fsp_framer.sv ----
`timescale 1ns/1ps
module fsp_framer (
    input wire logic run, // far side active
    input wire logic clkOn, // far side makes the clocks
    input wire logic actHigh, // act when clock goes high
    input wire logic fsFar, // far side drives tx sync
    input wire logic [31:0] rxWord, // word sent each frame
    input wire logic txClkPin, // resolved tx clock
    input wire logic rxClkPin, // resolved rx clock
    input wire logic txFsPin, // resolved tx sync
    input wire logic txLine, // resolved tx data
    output logic farClk, // far bit clock
    output logic farRxSync, // far rx sync
    output logic farTxSync, // far tx sync
    output logic farRxData, // far rx data
    output logic [31:0] txWord, // first tx word
    output logic txGot, // first tx word done
    output logic fsTwice // sync high two bits running
);
    logic [5:0] txCnt;
    logic [4:0] rxBit;
    logic [4:0] txLead;
    logic fsPrev;
    initial farClk = 1'b0;
    // stands still low while clkOn is low
    always #62.5 farClk = clkOn ? ~farClk : 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // launch on the edge opposite the device's sample edge
    always @(rxClkPin or negedge run) begin
        if (!run) begin
            rxBit = 5'h00;
            farRxSync = 1'b0;
            farRxData = 1'b1; // pulled up when idle
        end else if (rxClkPin == actHigh) begin
            farRxSync = (rxBit == 5'h00);
            farRxData = rxWord[5'h1f - rxBit];
            rxBit = rxBit + 5'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always @(txClkPin or negedge run) begin
        if (!run) begin
            txCnt = 6'h00;
            txLead = 5'h00;
            txGot = 1'b0;
            fsTwice = 1'b0;
            fsPrev = 1'b0;
            farTxSync = 1'b0;
        end else if (txClkPin == actHigh) begin
            fsTwice = fsTwice | (txFsPin & fsPrev);
            txWord = {txWord[30:0], txLine};
            // own sync seen last edge: this bit is frame bit 0
            if (fsFar ? fsPrev : txFsPin)
                txCnt = 6'h01;
            else if (txCnt != 6'h00 && txCnt < 6'h20)
                txCnt = txCnt + 6'h01;
            fsPrev = txFsPin;
            if (txCnt == 6'h20)
                txGot = 1'b1;
        end else begin
            // sync goes out on the device's launch edge
            farTxSync = fsFar && (txLead == 5'h00);
            txLead = txLead + 5'h01;
        end
    end
endmodule

// ---- fsp_params.svh ----
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
// Operation
// - The transmit frame-sync pin is an input or an output under software control, driving or following frame alignment.
// - The receive frame-sync pin is an input or an output, so either side can supply receive frame alignment.
// - The transmit bit clock is an input or an output, runs from 512 KHz to 8.192 MHz, and shifts transmit data out.
// - The receive bit clock is an input or an output, runs from 512 KHz to 8.192 MHz, and samples receive data.
// - Transmit frame sync and data are launched on the configured rising or falling transmit clock edge.
// - Each receive bit is captured on the configured rising or falling receive clock edge.
// - After reset all clock and frame-sync pins are inputs until software selects otherwise.
// - Transmit data is open-drain: pulled low for a zero and released for a one.
// - With the port disabled none of its pins is driven, so none needs a connection.

// register byte offsets
`define FSP_OFF_CTRL 8'h00
`define FSP_OFF_DIV 8'h04
`define FSP_OFF_FLEN 8'h08
`define FSP_OFF_TXDATA 8'h0c
`define FSP_OFF_RXDATA 8'h10
`define FSP_OFF_STATUS 8'h14

// control fields
`define FSP_CTRL_EN 0
`define FSP_CTRL_TXCLK_OUT 1
`define FSP_CTRL_RXCLK_OUT 2
`define FSP_CTRL_TXFS_OUT 3
`define FSP_CTRL_RXFS_OUT 4
`define FSP_CTRL_TXEDGE 5
`define FSP_CTRL_RXEDGE 6
`define FSP_CTRL_BITS 7

// status fields
`define FSP_ST_TXFULL 0
`define FSP_ST_RXVALID 1
`define FSP_ST_OVERRUN 2
`define FSP_ST_UNDERRUN 3

// reset values
`define FSP_CTRL_RST 7'h00
`define FSP_DIV_RST 8'h3d
`define FSP_FLEN_RST 8'hff

// timing
`define FSP_REF_KHZ 125000
`define FSP_MIN_KHZ 512
`define FSP_MAX_KHZ 8192
`define FSP_HALF_MIN ((`FSP_REF_KHZ + 2 * `FSP_MAX_KHZ - 1) / (2 * `FSP_MAX_KHZ))
`define FSP_HALF_MAX (`FSP_REF_KHZ / (2 * `FSP_MIN_KHZ))
`endif

// ---- fsp_pkg.sv ----
package fsp_pkg;
    typedef enum logic [2:0] {
        FSP_OFF = 3'b001,
        FSP_HUNT = 3'b010,
        FSP_RUN = 3'b100
    } fsp_state_t;
endpackage

// ---- fsp_port.sv ----
`timescale 1ns/1ps
`include "fsp_params.svh"
module fsp_port (
    input wire logic ref_clk, // system clock, 125 MHz
    input wire logic rst_n, // synchronous reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic txBitClockIn, // tx bit clock pin level
    output logic txBitClockOut, // tx bit clock drive
    output logic txBitClockOe, // tx bit clock enable
    input wire logic rxBitClockIn, // rx bit clock pin level
    output logic rxBitClockOut, // rx bit clock drive
    output logic rxBitClockOe, // rx bit clock enable
    input wire logic txFrameSyncIn, // tx frame sync pin level
    output logic txFrameSyncOut, // tx frame sync drive
    output logic txFrameSyncOe, // tx frame sync enable
    input wire logic rxFrameSyncIn, // rx frame sync pin level
    output logic rxFrameSyncOut, // rx frame sync drive
    output logic rxFrameSyncOe, // rx frame sync enable
    output logic txSerialOut, // tx data drive, always low
    output logic txSerialOe, // tx data pull-down enable
    input wire logic rxSerialIn // rx data pin level
);
    ////////////////////////////////////////////////////////////////////
    logic [`FSP_CTRL_BITS-1:0] ctrl;
    logic [7:0] divHalf;
    logic [7:0] frameLen;
    logic [31:0] txHold;
    logic [31:0] rxHold;
    logic txFull;
    logic rxValid;
    logic overrun;
    logic underrun;

    wire en = ctrl[`FSP_CTRL_EN];
    wire [1:0] clkOutSel = {ctrl[`FSP_CTRL_RXCLK_OUT],
                            ctrl[`FSP_CTRL_TXCLK_OUT]};
    wire [1:0] clkPin = {rxBitClockIn, txBitClockIn};
    wire [1:0] fsPin = {rxFrameSyncIn, txFrameSyncIn};
    // half period clamped into the legal bit clock range
    wire [7:0] halfLo = 8'(`FSP_HALF_MIN);
    wire [7:0] halfHi = 8'(`FSP_HALF_MAX);
    wire [7:0] halfEff = (divHalf < halfLo) ? halfLo :
                         (divHalf > halfHi) ? halfHi : divHalf;

    ////////////////////////////////////////////////////////////////////
    // per link clock: generator, pin synchroniser, edge finder
    logic clkGen [2];
    logic clkRise [2];
    logic clkFall [2];
    logic fsSync [2];
    logic next_clkGen [2];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_clk
            logic [7:0] divCnt;
            logic c1, c2, c3;
            logic f1, f2;
            wire tick = (divCnt == 8'h00);
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    divCnt <= 8'h00;
                    clkGen[gi] <= 1'b0;
                    c1 <= 1'b0;
                    c2 <= 1'b0;
                    c3 <= 1'b0;
                    f1 <= 1'b0;
                    f2 <= 1'b0;
                end else begin
                    c1 <= clkPin[gi];
                    c2 <= c1;
                    c3 <= c2;
                    f1 <= fsPin[gi];
                    f2 <= f1;
                    if (!en || !clkOutSel[gi]) begin
                        divCnt <= 8'h00;
                        clkGen[gi] <= 1'b0;
                    end else if (tick) begin
                        divCnt <= 8'(halfEff - 8'h01);
                        clkGen[gi] <= ~clkGen[gi];
                    end else begin
                        divCnt <= 8'(divCnt - 8'h01);
                    end
                end
            end
            // edges of the generated clock fall on the toggle itself
            assign clkRise[gi] = clkOutSel[gi] ?
                (en && tick && !clkGen[gi]) : (c2 && !c3);
            assign clkFall[gi] = clkOutSel[gi] ?
                (en && tick && clkGen[gi]) : (!c2 && c3);
            assign fsSync[gi] = f2;
            // pin moves in the same cycle as the data launched off it
            assign next_clkGen[gi] = (!en || !clkOutSel[gi]) ? 1'b0 :
                (tick ? ~clkGen[gi] : clkGen[gi]);
        end
    endgenerate

    logic d1, d2;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            d1 <= 1'b0;
            d2 <= 1'b0;
        end else begin
            d1 <= rxSerialIn;
            d2 <= d1;
        end
    end

    wire txFsOutSel = ctrl[`FSP_CTRL_TXFS_OUT];
    wire rxFsOutSel = ctrl[`FSP_CTRL_RXFS_OUT];
    wire txLaunch = ctrl[`FSP_CTRL_TXEDGE] ? clkFall[0] : clkRise[0];
    wire txSample = ctrl[`FSP_CTRL_TXEDGE] ? clkRise[0] : clkFall[0];
    wire rxSample = ctrl[`FSP_CTRL_RXEDGE] ? clkFall[1] : clkRise[1];
    wire rxLaunch = ctrl[`FSP_CTRL_RXEDGE] ? clkRise[1] : clkFall[1];

    ////////////////////////////////////////////////////////////////////
    // transmit
    fsp_pkg::fsp_state_t txState;
    logic [7:0] txCnt;
    logic [31:0] txShift;
    logic txPend;

    wire txSyncSeen = !txFsOutSel && txSample && fsSync[0];
    wire [7:0] txCntEff = txPend ? 8'h00 : txCnt;
    wire txWordStart = (txCntEff[4:0] == 5'h00);
    wire txLoad = (txState == fsp_pkg::FSP_RUN) && txLaunch && txWordStart;
    // underrun sends ones, i.e. the line stays released
    wire [31:0] txNext = txWordStart ? (txFull ? txHold : 32'hffffffff)
                                     : {txShift[30:0], 1'b1};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            txState <= fsp_pkg::FSP_OFF;
            txCnt <= 8'h00;
            txShift <= 32'hffffffff;
            txPend <= 1'b0;
            txSerialOe <= 1'b0;
            txFrameSyncOut <= 1'b0;
        end else begin
            case (txState)
                fsp_pkg::FSP_OFF: begin
                    txSerialOe <= 1'b0;
                    txFrameSyncOut <= 1'b0;
                    txPend <= 1'b0;
                    txCnt <= 8'h00;
                    if (en) begin
                        txState <= txFsOutSel ? fsp_pkg::FSP_RUN
                                              : fsp_pkg::FSP_HUNT;
                    end
                end
                fsp_pkg::FSP_HUNT: begin
                    if (!en) begin
                        txState <= fsp_pkg::FSP_OFF;
                    end else if (txSyncSeen) begin
                        txPend <= 1'b1;
                        txState <= fsp_pkg::FSP_RUN;
                    end
                end
                fsp_pkg::FSP_RUN: begin
                    if (!en) begin
                        txState <= fsp_pkg::FSP_OFF;
                    end else begin
                        if (txSyncSeen) begin
                            txPend <= 1'b1;
                        end else if (txLaunch) begin
                            txPend <= 1'b0;
                        end
                        if (txLaunch) begin
                            txShift <= txNext;
                            txSerialOe <= ~txNext[31];
                            txFrameSyncOut <= txFsOutSel &&
                                (txCntEff == 8'h00);
                            txCnt <= (txCntEff == frameLen) ? 8'h00
                                     : 8'(txCntEff + 8'h01);
                        end
                    end
                end
                default: txState <= fsp_pkg::FSP_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive
    fsp_pkg::fsp_state_t rxState;
    logic [7:0] rxCnt;
    logic [31:0] rxShift;

    wire rxSyncSeen = !rxFsOutSel && fsSync[1];
    wire [7:0] rxCntEff = rxSyncSeen ? 8'h00 : rxCnt;
    wire rxTake = rxSample && ((rxState == fsp_pkg::FSP_RUN) ||
        ((rxState == fsp_pkg::FSP_HUNT) && rxSyncSeen));
    wire [31:0] rxNext = {rxShift[30:0], d2};
    wire rxWordDone = rxTake && (rxCntEff[4:0] == 5'h1f);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rxState <= fsp_pkg::FSP_OFF;
            rxCnt <= 8'h00;
            rxShift <= 32'h00000000;
            rxFrameSyncOut <= 1'b0;
        end else begin
            case (rxState)
                fsp_pkg::FSP_OFF: begin
                    rxCnt <= 8'h00;
                    rxFrameSyncOut <= 1'b0;
                    if (en) begin
                        rxState <= rxFsOutSel ? fsp_pkg::FSP_RUN
                                              : fsp_pkg::FSP_HUNT;
                    end
                end
                fsp_pkg::FSP_HUNT,
                fsp_pkg::FSP_RUN: begin
                    if (!en) begin
                        rxState <= fsp_pkg::FSP_OFF;
                    end else begin
                        if (rxTake) begin
                            rxState <= fsp_pkg::FSP_RUN;
                            rxShift <= rxNext;
                            rxCnt <= (rxCntEff == frameLen) ? 8'h00
                                     : 8'(rxCntEff + 8'h01);
                        end
                        // own sync leads the first bit by half a period
                        if (rxLaunch) begin
                            rxFrameSyncOut <= rxFsOutSel &&
                                (rxCnt == 8'h00);
                        end
                    end
                end
                default: rxState <= fsp_pkg::FSP_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin drivers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            txBitClockOe <= 1'b0;
            rxBitClockOe <= 1'b0;
            txFrameSyncOe <= 1'b0;
            rxFrameSyncOe <= 1'b0;
            txBitClockOut <= 1'b0;
            rxBitClockOut <= 1'b0;
            txSerialOut <= 1'b0;
        end else begin
            txBitClockOe <= en && clkOutSel[0];
            rxBitClockOe <= en && clkOutSel[1];
            txFrameSyncOe <= en && txFsOutSel;
            rxFrameSyncOe <= en && rxFsOutSel;
            txBitClockOut <= next_clkGen[0];
            rxBitClockOut <= next_clkGen[1];
            txSerialOut <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave, one wait state
    wire access = psel && penable && !pready;
    wire done = psel && penable && pready;
    wire selCtrl = (paddr == `FSP_OFF_CTRL);
    wire selDiv = (paddr == `FSP_OFF_DIV);
    wire selFlen = (paddr == `FSP_OFF_FLEN);
    wire selTx = (paddr == `FSP_OFF_TXDATA);
    wire selRx = (paddr == `FSP_OFF_RXDATA);
    wire selSt = (paddr == `FSP_OFF_STATUS);
    wire mapped = selCtrl || selDiv || selFlen || selTx || selRx || selSt;
    wire wrEn = done && pwrite && mapped;
    wire rdRx = done && !pwrite && selRx;
    wire [3:0] status = {underrun, overrun, rxValid, txFull};
    wire [31:0] readMux =
        selCtrl ? {25'h0, ctrl} :
        selDiv ? {24'h000000, divHalf} :
        selFlen ? {24'h000000, frameLen} :
        selTx ? txHold :
        selRx ? rxHold :
        selSt ? {28'h0000000, status} : 32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access && !mapped;
            prdata <= (access && !pwrite) ? readMux : 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl <= `FSP_CTRL_RST;
            divHalf <= `FSP_DIV_RST;
            frameLen <= `FSP_FLEN_RST;
            txHold <= 32'h00000000;
            txFull <= 1'b0;
            rxHold <= 32'h00000000;
            rxValid <= 1'b0;
            overrun <= 1'b0;
            underrun <= 1'b0;
        end else begin
            if (wrEn && selCtrl) begin
                ctrl <= pwdata[`FSP_CTRL_BITS-1:0];
            end
            if (wrEn && selDiv) begin
                divHalf <= pwdata[7:0];
            end
            if (wrEn && selFlen) begin
                frameLen <= pwdata[7:0];
            end
            if (wrEn && selTx) begin
                txHold <= pwdata;
            end
            // a write beside a load refills the emptied holding word
            txFull <= (wrEn && selTx) ? 1'b1 : (txLoad ? 1'b0 : txFull);
            if (rxWordDone) begin
                rxHold <= rxNext;
            end
            // hardware set beats software clear
            rxValid <= rxWordDone || (rxValid && !rdRx);
            overrun <= (rxWordDone && rxValid && !rdRx) ||
                (overrun && !(wrEn && selSt && pwdata[`FSP_ST_OVERRUN]));
            underrun <= (txLoad && !txFull) ||
                (underrun && !(wrEn && selSt && pwdata[`FSP_ST_UNDERRUN]));
        end
    end
endmodule

// ---- fsp_port_checker.sv ----
`timescale 1ns/1ps
module fsp_port_checker (
    input wire logic ref_clk, // clock
    input wire logic rst_n, // reset
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic [7:0] paddr, // apb
    input wire logic [31:0] prdata, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic txBitClockOut, // pin
    input wire logic txBitClockOe, // pin
    input wire logic rxBitClockOe, // pin
    input wire logic txFrameSyncOut, // pin
    input wire logic txFrameSyncOe, // pin
    input wire logic rxFrameSyncOe, // pin
    input wire logic txSerialOut, // pin
    input wire logic txSerialOe // pin
);
    logic [7:0] fsHigh;
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // slowest input clock gives about 244 cycles per bit
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !txFrameSyncOe || !txFrameSyncOut)
            fsHigh <= 8'h00;
        else
            fsHigh <= fsHigh + 8'h01;
    end
    sequence accessStart;
        psel && penable && !$past(penable);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_apb_wait: assert property (accessStart |=> pready)
        else $error("no ready after one wait cycle");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_ready_owned: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready outside an access");
    chk_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    chk_err_qualified: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_unmapped_err: assert property (accessStart ##0 paddr > 8'h14 |=> pslverr)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (accessStart ##0
        (paddr <= 8'h14 && paddr[1:0] == 2'b00) |=> !pslverr)
        else $error("mapped access refused");
    chk_reset_idle: assert property (@(posedge ref_clk) disable iff (1'b0)
        !rst_n |=> !(txBitClockOe || rxBitClockOe || txFrameSyncOe
        || rxFrameSyncOe || txSerialOe))
        else $error("pin driven after reset");
    chk_od_low: assert property (txSerialOut == 1'b0)
        else $error("data pin driven high");
    chk_fs_one_bit: assert property (fsHigh <= 8'hfa)
        else $error("frame sync held too long");
    chk_fs_launch: assert property (txFrameSyncOe && txBitClockOe
        && $past(txBitClockOe) && $changed(txFrameSyncOut)
        |-> $changed(txBitClockOut))
        else $error("frame sync moved off a clock edge");
    chk_data_launch: assert property (txBitClockOe && $past(txBitClockOe)
        && $changed(txSerialOe) |-> $changed(txBitClockOut))
        else $error("data moved off a clock edge");
endmodule
bind fsp_port fsp_port_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txBitClockOut(txBitClockOut),
    .txBitClockOe(txBitClockOe), .rxBitClockOe(rxBitClockOe),
    .txFrameSyncOut(txFrameSyncOut), .txFrameSyncOe(txFrameSyncOe),
    .rxFrameSyncOe(rxFrameSyncOe), .txSerialOut(txSerialOut),
    .txSerialOe(txSerialOe));

// ---- fsp_port_test.sv ----
`timescale 1ns/1ps
module fsp_port_test;
    logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, run = 1'b0, clkOn = 1'b0, actHigh = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rxWord = 32'h0, prdata, txWord;
    logic pready, pslverr, txBitClockOut, txBitClockOe, rxBitClockOut;
    logic rxBitClockOe, txFrameSyncOut, txFrameSyncOe, rxFrameSyncOut;
    logic rxFrameSyncOe, txSerialOut, txSerialOe, farClk, farRxSync;
    logic farRxData, txGot, fsTwice, farTxSync, fsFar = 1'b0;
    wire logic txClkPin = txBitClockOe ? txBitClockOut : farClk;
    wire logic rxClkPin = rxBitClockOe ? rxBitClockOut : farClk;
    wire logic txFsPin = txFrameSyncOe ? txFrameSyncOut : farTxSync;
    wire logic rxFsPin = rxFrameSyncOe ? rxFrameSyncOut : farRxSync;
    wire logic txLine = txSerialOe ? txSerialOut : 1'b1;
    int miscompares = 0;
    int checks = 0;
    always #4 ref_clk = ~ref_clk;
    fsp_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txBitClockIn(txClkPin), .txBitClockOut(txBitClockOut),
        .txBitClockOe(txBitClockOe), .rxBitClockIn(rxClkPin),
        .rxBitClockOut(rxBitClockOut), .rxBitClockOe(rxBitClockOe),
        .txFrameSyncIn(txFsPin), .txFrameSyncOut(txFrameSyncOut),
        .txFrameSyncOe(txFrameSyncOe), .rxFrameSyncIn(rxFsPin),
        .rxFrameSyncOut(rxFrameSyncOut), .rxFrameSyncOe(rxFrameSyncOe),
        .txSerialOut(txSerialOut), .txSerialOe(txSerialOe),
        .rxSerialIn(farRxData));
    fsp_framer u_far (.run(run), .clkOn(clkOn), .actHigh(actHigh),
        .fsFar(fsFar), .farTxSync(farTxSync),
        .rxWord(rxWord), .txClkPin(txClkPin), .rxClkPin(rxClkPin),
        .txFsPin(txFsPin), .txLine(txLine), .farClk(farClk),
        .farRxSync(farRxSync), .farRxData(farRxData), .txWord(txWord),
        .txGot(txGot), .fsTwice(fsTwice));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic timeout;
        miscompares++;
        $display("ERROR %0t wait ran out", $time);
        conclude();
    endtask
    // entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            timeout();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
            input logic expErr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, expErr});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int m, n, k;
        logic g, pt, pr, e;
        logic [31:0] r, txExp;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check({txBitClockOe, rxBitClockOe, txFrameSyncOe, rxFrameSyncOe,
            txSerialOe}, 32'h0);
        rd(8'h00, 32'h0, 1'b0);
        rd(8'h04, 32'h3d, 1'b0);
        rd(8'h08, 32'hff, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        apb(1'b1, 8'h08, 32'h1f, r, e);
        // above the fastest rate, so the clamp must hold it
        apb(1'b1, 8'h04, 32'h02, r, e);
        $display("reset test done");
        for (m = 0; m < 4; m++) begin
            g = m[1];
            txExp = 32'h3c5a_e187 ^ m;
            run <= 1'b1;
            clkOn <= !g;
            actHigh <= m[0];
            // falling-launch modes take the tx sync from the far side
            fsFar <= m[0];
            rxWord <= 32'h96c3_a50f + m;
            apb(1'b1, 8'h0c, txExp, r, e);
            apb(1'b1, 8'h00, 32'h01 | (g ? 32'h06 : 32'h0)
                | (m[0] ? 32'h60 : 32'h08), r, e);
            if (g) begin
                n = 0;
                k = 0;
                pt = txBitClockOut;
                pr = rxBitClockOut;
                repeat (64) begin
                    @(posedge ref_clk);
                    n += (txBitClockOut !== pt);
                    k += (rxBitClockOut !== pr);
                    pt = txBitClockOut;
                    pr = rxBitClockOut;
                end
                check(n, 32'h8);
                check(k, 32'h8);
            end
            k = 0;
            while (txGot !== 1'b1 && k < 3000) begin
                @(posedge ref_clk);
                k++;
            end
            if (txGot !== 1'b1)
                timeout();
            check(txWord, txExp);
            check({31'h0, fsTwice}, 32'h0);
            check({txBitClockOe, rxBitClockOe, txFrameSyncOe, rxFrameSyncOe},
                {28'h0, g, g, !m[0], 1'b0});
            k = 0;
            do begin
                apb(1'b0, 8'h14, 32'h0, r, e);
                k++;
            end while (r[1] !== 1'b1 && k < 500);
            if (r[1] !== 1'b1)
                timeout();
            rd(8'h10, 32'h96c3_a50f + m, 1'b0);
            apb(1'b1, 8'h00, 32'h0, r, e);
            repeat (2) @(posedge ref_clk);
            check({txBitClockOe, rxBitClockOe, txFrameSyncOe, rxFrameSyncOe,
                txSerialOe}, 32'h0);
            run <= 1'b0;
            clkOn <= 1'b0;
            @(posedge ref_clk);
            $display("mode %0d test done", m);
        end
        conclude();
    end
endmodule
